// ==== hdl/sbdb_pkg.sv ====
// constants, types and helpers for the serial data buffer and baud generator
// Operation
// RL1 - reading the data address returns the last received byte; it cannot be written
// RL2 - writing the data address queues a transmit byte, received byte untouched
// RL3 - reset leaves the data buffer contents as they were
// RL4 - software avoids read-modify-write on the data address
// RL5 - one baud register sets the rate for receiver and transmitter alike
// RL6 - prescaler code 00,01,10,11 divides by 1,3,4,13
// RL7 - reset clears both prescaler bits, prescaler divides by one
// RL8 - rate select code n divides by two to the n, 1 to 128
// RL9 - reset clears the rate select bits, rate divides by one
// RL10 - bit rate is bus frequency over 64 times prescaler times rate divisor
// RL11 - clock source select high lets the bus clock drive the prescaler
// RL12 - unused baud register bits read zero and ignore writes
package sbdb_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] SBDB_DATA_ADDR = 16'h0018;
  localparam logic [15:0] SBDB_BAUD_ADDR = 16'h0019;

  // baud register field layout
  localparam int SBDB_PRE_LSB = 4;
  localparam int SBDB_RATE_LSB = 0;
  localparam logic [1:0] SBDB_PRE_RST = 2'h0;
  localparam logic [2:0] SBDB_RATE_RST = 3'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SBDB_CLK_MHZ = 100;
  localparam int SBDB_CLK_PERIOD_NS = 10;
  localparam logic [5:0] SBDB_BIT_DIV_LAST = 6'h3f; // 64 rate divider ticks per bit
  localparam int SBDB_FIFO_DEPTH = 4;
  localparam int SBDB_BYTE_W = 8;

  typedef struct packed {
    logic [1:0] pre_sel;
    logic [2:0] rate_sel;
  } sbdb_baud_cfg_t;

  // last count of the prescaler for each code (divisor minus one)
  function automatic logic [3:0] sbdb_pre_last(input logic [1:0] sel);
    case (sel)
      2'h0: sbdb_pre_last = 4'h0;
      2'h1: sbdb_pre_last = 4'h2;
      2'h2: sbdb_pre_last = 4'h3;
      default: sbdb_pre_last = 4'hc;
    endcase
  endfunction

  // mask of low rate counter bits that must all be one for a tick
  function automatic logic [6:0] sbdb_rate_mask(input logic [2:0] sel);
    sbdb_rate_mask = 7'(((8'h01 << sel) - 8'h01) & 8'h7f);
  endfunction

endpackage

// ==== hdl/sbdb_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sbdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready = (count_r != FULL_CNT);
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset, but the pointer and count reset empties the queue anyway
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_push_count: assert property (@(posedge clk) disable iff (!arst_n) // [RL2]
    push && !pop |=> count_r == $past(count_r) + 1'b1)
    else $error("fifo count did not grow on push");
  a_fifo_no_over: assert property (@(posedge clk) disable iff (!arst_n) // [RL2]
    count_r <= FULL_CNT)
    else $error("fifo count beyond depth");
  c_fifo_full: cover property (@(posedge clk) disable iff (!arst_n) count_r == FULL_CNT);
endmodule // sbdb_fifo
`default_nettype wire

// ==== hdl/sbdb_top.sv ====
// serial data buffer and shared baud rate generator
`timescale 1ns/1ps
`default_nettype none
module sbdb_top
  import sbdb_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [15:0] ADDR,
  input wire logic RD_EN,
  input wire logic WR_EN,
  input wire logic [7:0] WR_DATA,
  output logic [7:0] RD_DATA,
  input wire logic BAUD_CLOCK_SOURCE_SEL,
  input wire logic ALT_CLK_TICK,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  output logic [7:0] TX_BYTE,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic TX_FULL,
  output logic BIT_TICK
);

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  // receive byte, baud fields and the queue handshake nets
  logic [7:0] received_byte_r;
  sbdb_baud_cfg_t cfg_r;
  logic data_sel;
  logic baud_sel;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out_data;

  // address decode; any other address reads zero and writes nowhere
  assign data_sel = (ADDR == SBDB_DATA_ADDR);
  assign baud_sel = (ADDR == SBDB_BAUD_ADDR);

  // receive side: only the receiver loads it, no reset so contents survive
  always_ff @(posedge SYS_CLK) begin
    if (RX_VALID) begin
      received_byte_r <= RX_BYTE; // [RL1] [RL3]
    end
  end

  // baud config: only the defined fields are stored
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_r.pre_sel <= SBDB_PRE_RST; // [RL7]
      cfg_r.rate_sel <= SBDB_RATE_RST; // [RL9]
    end else if (WR_EN && baud_sel) begin
      cfg_r.pre_sel <= WR_DATA[SBDB_PRE_LSB +: 2]; // [RL12]
      cfg_r.rate_sel <= WR_DATA[SBDB_RATE_LSB +: 3];
    end
  end

  // read data registered; the answer appears one cycle after RD_EN
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RD_DATA <= 8'h00;
    end else if (RD_EN) begin
      RD_DATA <= 8'h00;
      if (data_sel) begin
        RD_DATA <= received_byte_r; // [RL1]
      end else if (baud_sel) begin
        RD_DATA[SBDB_PRE_LSB +: 2] <= cfg_r.pre_sel; // [RL12]
        RD_DATA[SBDB_RATE_LSB +: 3] <= cfg_r.rate_sel;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit queue
  // ---------------------------------------------------------------
  // four queued bytes plus the output stage give five bytes of slack
  // before software has to poll the full flag
  // a write to the data address only enters the queue; a full queue drops it
  sbdb_fifo #(
    .WIDTH(SBDB_BYTE_W),
    .DEPTH(SBDB_FIFO_DEPTH)
  ) u_txq (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .in_valid(WR_EN && data_sel), // [RL2]
    .in_ready(fifo_in_ready),
    .in_data(WR_DATA),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // output stage keeps TX_BYTE/TX_VALID on flops; refills when empty or taken
  // the stage refills in the cycle it hands a byte over, so there is no bubble
  assign fifo_pop = fifo_out_valid && (!TX_VALID || TX_READY);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_VALID <= 1'b0;
    end else if (!TX_VALID || TX_READY) begin
      TX_VALID <= fifo_out_valid;
    end
  end

  // byte register needs no reset; TX_VALID guards it
  always_ff @(posedge SYS_CLK) begin
    if (fifo_pop) begin
      TX_BYTE <= fifo_out_data;
    end
  end

  // full flag lags the queue by one cycle, so poll it before writing
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TX_FULL <= 1'b0;
    end else begin
      TX_FULL <= !fifo_in_ready;
    end
  end

  // ---------------------------------------------------------------
  // baud rate generator
  // ---------------------------------------------------------------
  // counters are narrow on purpose: 13 needs four bits, 128 needs seven
  logic src_en;
  logic [3:0] pre_cnt_r;
  logic pre_tick;
  logic [6:0] rate_cnt_r;
  logic rate_tick;
  logic [5:0] bit_cnt_r;

  // the alternate tick keeps all counters frozen between its pulses
  // bus clock or the alternate tick feeds the prescaler
  assign src_en = BAUD_CLOCK_SOURCE_SEL ? 1'b1 : ALT_CLK_TICK; // [RL11]
  assign pre_tick = src_en && (pre_cnt_r >= sbdb_pre_last(cfg_r.pre_sel));
  assign rate_tick = pre_tick &&
    ((rate_cnt_r & sbdb_rate_mask(cfg_r.rate_sel)) == sbdb_rate_mask(cfg_r.rate_sel));

  // prescaler: >= keeps it safe when the code shrinks mid-count
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_cnt_r <= 4'h0;
    end else if (pre_tick) begin
      pre_cnt_r <= 4'h0; // [RL6]
    end else if (src_en) begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end

  // a mask compare avoids one comparator per rate code
  // rate divider: free counter, tick when the selected low bits are all one
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rate_cnt_r <= 7'h00;
    end else if (pre_tick) begin
      rate_cnt_r <= rate_cnt_r + 7'h01; // [RL8]
    end
  end

  // the tick is delayed one cycle so that BIT_TICK leaves a flop
  // final divide by 64; one tick shared by receiver and transmitter
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bit_cnt_r <= 6'h00;
      BIT_TICK <= 1'b0;
    end else begin
      BIT_TICK <= rate_tick && (bit_cnt_r == SBDB_BIT_DIV_LAST); // [RL10] [RL5]
      if (rate_tick) begin
        bit_cnt_r <= bit_cnt_r + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_rx_read_back: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL1]
    RD_EN && data_sel |=> RD_DATA == $past(received_byte_r))
    else $error("data read did not return received byte");
  a_rx_write_proof: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL2]
    WR_EN && data_sel && !RX_VALID |=> received_byte_r == $past(received_byte_r))
    else $error("write disturbed received byte");
  a_pre_bound: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6]
    cfg_r.pre_sel == 2'h3 && pre_tick |-> pre_cnt_r == 4'hc)
    else $error("prescaler 13 did not wrap after twelve");
  a_pre_unity: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL6] [RL7]
    cfg_r.pre_sel == 2'h0 && src_en |=> pre_cnt_r == 4'h0)
    else $error("prescaler one did not tick every enable");
  a_rate_mask: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL8]
    cfg_r.rate_sel == 3'h7 && rate_tick |-> rate_cnt_r == 7'h7f)
    else $error("rate divisor 128 ticked early");
  a_bit_tick: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL10]
    BIT_TICK |-> $past(bit_cnt_r) == SBDB_BIT_DIV_LAST && $past(rate_tick))
    else $error("bit tick not at count 63");
  a_src_gate: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL11]
    !BAUD_CLOCK_SOURCE_SEL && !ALT_CLK_TICK |=> pre_cnt_r == $past(pre_cnt_r))
    else $error("prescaler ran without a source tick");
  a_unused_zero: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL12]
    RD_EN && baud_sel |=> RD_DATA[7:6] == 2'h0 && RD_DATA[3] == 1'b0)
    else $error("unused baud bits read nonzero");
  a_cfg_reset: assert property (@(posedge SYS_CLK) // [RL7] [RL9]
    $rose(ARST_N) |-> cfg_r.pre_sel == 2'h0 && cfg_r.rate_sel == 3'h0)
    else $error("baud fields not cleared by reset");

  // receive load, held transmit offer and the single shared baud store
  a_rx_load: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL1]
    RX_VALID |=> received_byte_r == $past(RX_BYTE))
    else $error("received byte not loaded");
  a_tx_hold: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL2]
    TX_VALID && !TX_READY |=> TX_VALID && TX_BYTE == $past(TX_BYTE))
    else $error("transmit offer changed before it was taken");
  a_baud_store: assert property (@(posedge SYS_CLK) disable iff (!ARST_N) // [RL5]
    WR_EN && baud_sel |=>
      cfg_r.pre_sel == $past(WR_DATA[SBDB_PRE_LSB +: 2]) &&
      cfg_r.rate_sel == $past(WR_DATA[SBDB_RATE_LSB +: 3]))
    else $error("baud write not stored");

  c_bit_tick: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) BIT_TICK);
  c_tx_sent: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) TX_VALID && TX_READY);
  c_tx_full: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) TX_FULL && WR_EN && data_sel);
  c_max_div: cover property (@(posedge SYS_CLK) disable iff (!ARST_N)
    cfg_r.pre_sel == 2'h3 && cfg_r.rate_sel == 3'h7 && rate_tick);
endmodule // sbdb_top
`default_nettype wire

// ==== sim/sbdb_partner.sv ====
// remote serial end: feeds received bytes and takes transmit bytes
`timescale 1ns/1ps
`default_nettype none
module sbdb_partner (
  input wire logic clk,
  input wire logic stall,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h5a;
  end
  // stalling holds ready low so the queue backs up
  assign tx_ready = !stall;
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_byte);
    end
  end
  // one-cycle pulse; byte lines flip after so a stale value is never mistaken
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1 rx_valid = 1'b1;
    rx_byte = b;
    @(posedge clk);
    #1 rx_valid = 1'b0;
    rx_byte = ~b;
  endtask
endmodule // sbdb_partner
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the serial data buffer and baud generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbdb_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic src_sel = 1'b1;
  logic alt_tick = 1'b0;
  logic stall = 1'b0;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_ready;
  logic [7:0] rd_data;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_full;
  logic bit_tick;
  logic [7:0] v;
  int mismatches = 0;
  int n_checks = 0;
  int gap;
  int pd[4] = '{1, 3, 4, 13};
  always #5 sys_clk = ~sys_clk;
  // alternate source pulses every other cycle
  always @(posedge sys_clk) alt_tick <= #1 ~alt_tick;
  sbdb_top sbdb_top_inst (.SYS_CLK(sys_clk), .ARST_N(arst_n), .ADDR(addr), .RD_EN(rd_en),
    .WR_EN(wr_en), .WR_DATA(wr_data), .RD_DATA(rd_data), .BAUD_CLOCK_SOURCE_SEL(src_sel),
    .ALT_CLK_TICK(alt_tick), .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .TX_BYTE(tx_byte),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_FULL(tx_full), .BIT_TICK(bit_tick));
  sbdb_partner sbdb_partner_inst (.clk(sys_clk), .stall(stall), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // plain writes only, the data address is never read back and rewritten
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge sys_clk);
    #1 wr_en = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 rd_en = 1'b1;
    addr = a;
    @(posedge sys_clk);
    #1 rd_en = 1'b0;
    @(negedge sys_clk);
    d = rd_data;
  endtask
  // cycles to the next tick; the first two after a change are skipped
  task automatic tick_gap(output int n);
    for (int w = 0; w < 3; w++) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (bit_tick !== 1'b1 && n < 20000);
      if (n >= 20000) begin
        mismatches++;
        final_report();
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    rd(SBDB_BAUD_ADDR, v);
    chk("baud after reset", 16'(v), 16'h0000);
    wr(SBDB_BAUD_ADDR, 8'hff);
    rd(SBDB_BAUD_ADDR, v);
    chk("baud unused bits", 16'(v), 16'h0037);
    rd(16'h0040, v);
    chk("unmapped read", 16'(v), 16'h0000);
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      wr(SBDB_BAUD_ADDR, 8'(p << 4));
      tick_gap(gap);
      chk("prescaled period", 16'(gap), 16'(64 * pd[p]));
    end
    for (int r = 1; r < 8; r++) begin
      wr(SBDB_BAUD_ADDR, 8'(r));
      tick_gap(gap);
      chk("rate period", 16'(gap), 16'(64 << r));
    end
    wr(SBDB_BAUD_ADDR, 8'h00);
    src_sel = 1'b0;
    tick_gap(gap);
    chk("alt source period", 16'(gap), 16'd128);
    @(posedge sys_clk);
    #1 src_sel = 1'b1;
    $display("test baud done");
    sbdb_partner_inst.send(8'ha5);
    rd(SBDB_DATA_ADDR, v);
    chk("received byte", 16'(v), 16'h00a5);
    wr(SBDB_DATA_ADDR, 8'h3c);
    repeat (4) @(negedge sys_clk);
    rd(SBDB_DATA_ADDR, v);
    chk("received after write", 16'(v), 16'h00a5);
    chk("sent byte", 16'(sbdb_partner_inst.got[0]), 16'h003c);
    sbdb_partner_inst.got.delete();
    $display("test data done");
    @(posedge sys_clk);
    #1 stall = 1'b1;
    for (int i = 0; i < 6; i++) wr(SBDB_DATA_ADDR, 8'(8'h10 + i));
    @(negedge sys_clk);
    chk("queue full", 16'(tx_full), 16'h0001);
    @(posedge sys_clk);
    #1 stall = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk("sent count", 16'(sbdb_partner_inst.got.size()), 16'd5);
    for (int i = 0; i < 5; i++) chk("sent order", 16'(sbdb_partner_inst.got[i]), 16'(8'h10 + i));
    $display("test queue done");
    wr(SBDB_BAUD_ADDR, 8'h25);
    @(posedge sys_clk);
    #1 arst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    rd(SBDB_DATA_ADDR, v);
    chk("data kept over reset", 16'(v), 16'h00a5);
    rd(SBDB_BAUD_ADDR, v);
    chk("baud cleared by reset", 16'(v), 16'h0000);
    $display("test reset done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
